// File: rst_ctrl_cfg.svh
// Purpose: Named constants for the reset source controller.
// Assumes: 50 MHz system clock, register port with 4-bit word addresses.
// Notes: Offsets are word indices on the plain register port.
`ifndef RST_CTRL_CFG_SVH
`define RST_CTRL_CFG_SVH
`define ADDR_CTRL 4'h0
`define ADDR_LVL 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_WDT_TIMEOUT 4'h3
`define ADDR_WDT_KICK 4'h4
`define ADDR_BUZZ 4'h5
`define ADDR_IRQ 4'h6
`define CTRL_SWRST 0
`define CTRL_SWRST_DIS 1
`define CTRL_WDT_EN 2
`define CTRL_ALV_RST 3
`define CTRL_DLV_RST 4
`define CTRL_AREG_DIS 5
`define ST_POR 0
`define ST_EXT 1
`define ST_SW 2
`define ST_WDT 3
`define ST_PREC 4
`define ST_ALV 5
`define ST_DLV 6
`define ST_AHV 7
`define POR_PULSE_NS 150
`define CLK_PERIOD_NS 20
`define POR_CYCLES (((`POR_PULSE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define EXT_GAP_US 10
`define EXT_GAP_CYCLES ((`EXT_GAP_US) * 1000 / (`CLK_PERIOD_NS))
`define WDT_TIMEOUT_RST 16'hFFFF
`define BUZZ_RST 16'h0400
`define LVL_RST 4'h0
`define HV_LEVEL 4'hF
`endif

// File: rst_ctrl_pkg.sv
// Purpose: Types for the reset source controller.
// Assumes: Included constants from rst_ctrl_cfg.svh.
// Notes: Holds the state machine type and the state record.
package rst_ctrl_pkg;
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_STRETCH,
		ST_RUN
	} seq_t;

	typedef struct packed {
		logic [7:0] mon;
		logic boot_done;
		logic sleep;
		logic buzz;
	} sense_t;

	typedef struct packed {
		seq_t seq;
		logic [3:0] por_cnt;
		logic [5:0] ctrl;
		logic [3:0] alv_lvl;
		logic [3:0] dlv_lvl;
		logic [7:0] status;
		logic [2:0] irq;
		logic [15:0] wdt_timeout;
		logic [15:0] wdt_cnt;
		logic [15:0] buzz_period;
		logic [15:0] buzz_cnt;
		logic buzz_on;
		logic [31:0] rdata;
		logic rst_a;
		logic rst_b;
		logic ext_s1;
		logic ext_s2;
		logic [2:0] mon_s1;
		logic [2:0] mon_s2;
		logic wake_req;
		logic irq_out;
	} state_t;
endpackage : rst_ctrl_pkg

// File: reset_source_controller.sv
// Purpose: Combines all reset sources into one device reset and keeps a cause record.
// Assumes: Analog comparators deliver trip levels; sleep state comes from the power manager.
// Notes: Reset release is synchronised through two flip-flops on i_clock.
// Functional notes
// - Supply leaving range resets device; monitors may interrupt first.
// - Device stays in reset while external reset input is low.
// - Device reset returns processor, peripherals and registers to reset state.
// - Readable status records reset causes and interrupts; cleared by power-on.
// - Power-on pulse lasts at least 150 ns, stretched while supplies ramp.
// - After boot, power-on monitor off; precise monitor supervises.
// - Precise monitor trip gives same reset as power-on monitor; here it keeps status and watchdog enable and skips the power-on sequence.
// - Digital precise monitor always on; analog regulator off disables analog part.
// - Precise monitor off in sleep except during buzz intervals.
// - Low-voltage trip levels 1.70 V to 5.45 V in 250 mV steps.
// - High-voltage monitor trips at fixed 5.75 V and raises interrupt.
// - Each low-voltage monitor can be set to reset instead of interrupt.
// - Low and high voltage monitors disabled until power-on sequence finishes.
// - Monitor interrupt during buzz wakes device before presenting interrupt.
// - Buzz interval is adjustable; software keeps it short.
// - External reset active low, pulled up, effective in sleep and hibernate.
// - Software reset bit, by processor or DMA, gives power-on style reset; here it keeps status and watchdog enable and skips the power-on sequence.
// - A control bit stops the software reset bit from resetting.
// - Watchdog resets device if not restarted before programmed timeout.
// - Power-on disables watchdog; enable bit sticks until next power-on.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "rst_ctrl_cfg.svh"

module reset_source_controller
	import rst_ctrl_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ext_reset_n,
	input wire logic i_por_trip,
	input wire logic i_prec_dig_trip,
	input wire logic i_prec_ana_trip,
	input wire logic [3:0] i_analog_supply_lvl,
	input wire logic [3:0] i_digital_supply_lvl,
	input wire logic i_analog_high_trip,
	input wire logic i_boot_done,
	input wire logic i_sleep,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_device_reset,
	output logic o_monitor_irq,
	output logic o_wake_req,
	output logic o_buzz,
	output logic o_prec_enable
);
	state_t s_r;
	state_t s_nxt;
	logic [7:0] cause;
	logic rst_any;
	logic mon_on;
	logic prec_on;
	logic alv_trip;
	logic dlv_trip;
	logic ahv_trip;

	// Trip when the supply code sits below the programmed level code.
	function automatic logic below(input logic [3:0] lvl, input logic [3:0] thr);
		below = lvl < thr;
	endfunction : below

	// Low and high monitors run only after the power-on sequence, the precise monitor only after boot; in sleep, only while buzzing.
	always_comb begin
		mon_on = (s_r.seq == ST_RUN) && (!i_sleep || s_r.buzz_on);
		prec_on = i_boot_done && (!i_sleep || s_r.buzz_on);
		alv_trip = mon_on && s_r.mon_s2[0];
		dlv_trip = mon_on && s_r.mon_s2[1];
		ahv_trip = mon_on && s_r.mon_s2[2];
	end

	// Gather every reset cause into one vector.
	always_comb begin
		cause = 8'h00;
		cause[`ST_POR] = i_por_trip && !i_boot_done;
		cause[`ST_EXT] = !s_r.ext_s2;
		cause[`ST_SW] = s_r.ctrl[`CTRL_SWRST] && !s_r.ctrl[`CTRL_SWRST_DIS];
		cause[`ST_WDT] = s_r.ctrl[`CTRL_WDT_EN] && (s_r.wdt_cnt >= s_r.wdt_timeout);
		cause[`ST_PREC] = prec_on && (i_prec_dig_trip ||
			(i_prec_ana_trip && !s_r.ctrl[`CTRL_AREG_DIS]));
		cause[`ST_ALV] = alv_trip && s_r.ctrl[`CTRL_ALV_RST];
		cause[`ST_DLV] = dlv_trip && s_r.ctrl[`CTRL_DLV_RST];
		// The power-on sequence holds the device reset until the least pulse has run out.
		rst_any = (|cause) || (s_r.seq != ST_RUN);
	end

	// Next-state logic for the whole block.
	always_comb begin
		s_nxt = s_r;
		s_nxt.ext_s1 = i_ext_reset_n;
		s_nxt.ext_s2 = s_r.ext_s1;
		s_nxt.mon_s1[0] = below(i_analog_supply_lvl, s_r.alv_lvl);
		s_nxt.mon_s1[1] = below(i_digital_supply_lvl, s_r.dlv_lvl);
		s_nxt.mon_s1[2] = i_analog_high_trip;
		s_nxt.mon_s2 = s_r.mon_s1;
		s_nxt.rdata = 32'h0000_0000;
		// Power-on sequence: hold, stretch to the least pulse, then run.
		case (s_r.seq)
			ST_HOLD: begin
				s_nxt.por_cnt = 4'h0;
				if (!i_por_trip) begin
					s_nxt.seq = ST_STRETCH;
				end
			end
			ST_STRETCH: begin
				if (i_por_trip) begin
					s_nxt.seq = ST_HOLD;
				end else if (s_r.por_cnt >= 4'(`POR_CYCLES)) begin
					s_nxt.seq = ST_RUN;
				end else begin
					s_nxt.por_cnt = s_r.por_cnt + 4'h1;
				end
			end
			default: begin
			end
		endcase
		// Buzz timer paces periodic monitor activity in sleep.
		if (!i_sleep) begin
			s_nxt.buzz_cnt = 16'h0000;
			s_nxt.buzz_on = 1'b0;
		end else if (s_r.buzz_cnt >= s_r.buzz_period) begin
			s_nxt.buzz_cnt = 16'h0000;
			s_nxt.buzz_on = 1'b1;
		end else begin
			s_nxt.buzz_cnt = s_r.buzz_cnt + 16'h0001;
			s_nxt.buzz_on = 1'b0;
		end
		// Watchdog counts while enabled.
		if (s_r.ctrl[`CTRL_WDT_EN] && s_r.wdt_cnt != 16'hFFFF) begin
			s_nxt.wdt_cnt = s_r.wdt_cnt + 16'h0001;
		end
		// Monitor interrupts are sticky; set wins over a clear below.
		s_nxt.irq[0] = s_r.irq[0] | (alv_trip && !s_r.ctrl[`CTRL_ALV_RST]);
		s_nxt.irq[1] = s_r.irq[1] | (dlv_trip && !s_r.ctrl[`CTRL_DLV_RST]);
		s_nxt.irq[2] = s_r.irq[2] | ahv_trip;
		// Register writes.
		if (i_wr) begin
			if (i_addr == `ADDR_CTRL) begin
				s_nxt.ctrl = i_wdata[5:0];
				s_nxt.ctrl[`CTRL_WDT_EN] = s_r.ctrl[`CTRL_WDT_EN] | i_wdata[`CTRL_WDT_EN];
			end else if (i_addr == `ADDR_LVL) begin
				s_nxt.alv_lvl = i_wdata[3:0];
				s_nxt.dlv_lvl = i_wdata[7:4];
			end else if (i_addr == `ADDR_STATUS) begin
				s_nxt.status = s_r.status & ~i_wdata[7:0];
			end else if (i_addr == `ADDR_WDT_TIMEOUT) begin
				s_nxt.wdt_timeout = i_wdata[15:0];
			end else if (i_addr == `ADDR_WDT_KICK) begin
				s_nxt.wdt_cnt = 16'h0000;
			end else if (i_addr == `ADDR_BUZZ) begin
				s_nxt.buzz_period = i_wdata[15:0];
			end else if (i_addr == `ADDR_IRQ) begin
				s_nxt.irq = s_r.irq & ~i_wdata[2:0];
			end
			s_nxt.irq[0] = s_nxt.irq[0] | (alv_trip && !s_r.ctrl[`CTRL_ALV_RST]);
			s_nxt.irq[1] = s_nxt.irq[1] | (dlv_trip && !s_r.ctrl[`CTRL_DLV_RST]);
			s_nxt.irq[2] = s_nxt.irq[2] | ahv_trip;
		end
		// Record causes and monitor interrupts; set wins over clear.
		s_nxt.status = s_nxt.status | cause | {ahv_trip, dlv_trip, alv_trip, 5'h00};
		// Register reads, data valid in the next cycle.
		if (i_rd) begin
			if (i_addr == `ADDR_CTRL) begin
				s_nxt.rdata = {26'h0, s_r.ctrl};
			end else if (i_addr == `ADDR_LVL) begin
				s_nxt.rdata = {24'h0, s_r.dlv_lvl, s_r.alv_lvl};
			end else if (i_addr == `ADDR_STATUS) begin
				s_nxt.rdata = {24'h0, s_r.status};
			end else if (i_addr == `ADDR_WDT_TIMEOUT) begin
				s_nxt.rdata = {16'h0, s_r.wdt_timeout};
			end else if (i_addr == `ADDR_WDT_KICK) begin
				s_nxt.rdata = {16'h0, s_r.wdt_cnt};
			end else if (i_addr == `ADDR_BUZZ) begin
				s_nxt.rdata = {16'h0, s_r.buzz_period};
			end else if (i_addr == `ADDR_IRQ) begin
				s_nxt.rdata = {29'h0, s_r.irq};
			end
		end
		// Wake first, then present the interrupt once awake.
		s_nxt.wake_req = i_sleep && (|s_nxt.irq);
		s_nxt.irq_out = !i_sleep && (|s_r.irq);
		// Release path of the device reset.
		s_nxt.rst_a = 1'b0;
		s_nxt.rst_b = s_r.rst_a;
		// Any cause resets ctrl (but the watchdog enable), levels, watchdog count and interrupts; timeout, buzz period and status keep their values.
		if (rst_any) begin
			s_nxt.ctrl = 6'h00;
			s_nxt.ctrl[`CTRL_WDT_EN] = s_r.ctrl[`CTRL_WDT_EN] && !cause[`ST_POR];
			s_nxt.alv_lvl = `LVL_RST;
			s_nxt.dlv_lvl = `LVL_RST;
			s_nxt.wdt_cnt = 16'h0000;
			s_nxt.irq = 3'h0;
			s_nxt.rst_a = 1'b1;
			s_nxt.rst_b = 1'b1;
		end
		// Power-on clears the record and the sticky watchdog enable.
		if (cause[`ST_POR]) begin
			s_nxt.status = 8'h01;
			s_nxt.seq = ST_HOLD;
		end
	end

	// State register; reset is a power-on event.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			s_r <= '0;
			s_r.seq <= ST_HOLD;
			s_r.wdt_timeout <= `WDT_TIMEOUT_RST;
			s_r.buzz_period <= `BUZZ_RST;
			s_r.ext_s1 <= 1'b1;
			s_r.ext_s2 <= 1'b1;
			s_r.rst_a <= 1'b1;
			s_r.rst_b <= 1'b1;
			s_r.status <= 8'h01;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flip-flops, except o_prec_enable, decoded from the sequence state.
	always_comb begin
		o_rdata = s_r.rdata;
		o_device_reset = s_r.rst_b;
		o_monitor_irq = s_r.irq_out;
		o_wake_req = s_r.wake_req;
		o_buzz = s_r.buzz_on;
		o_prec_enable = s_r.seq == ST_RUN;
	end

	a_ext_holds_reset: assert property (@(posedge i_clock) disable iff (i_rst)
		!s_r.ext_s2 |=> o_device_reset)
		else $error("external reset low did not hold device reset");
	a_release_two_stage: assert property (@(posedge i_clock) disable iff (i_rst)
		rst_any |=> o_device_reset ##1 (o_device_reset || $past(rst_any)))
		else $error("device reset released too early");
	a_swrst_blocked: assert property (@(posedge i_clock) disable iff (i_rst)
		s_r.ctrl[`CTRL_SWRST_DIS] |-> !cause[`ST_SW])
		else $error("software reset acted while disabled");
	a_wdt_sticky: assert property (@(posedge i_clock) disable iff (i_rst)
		(s_r.ctrl[`CTRL_WDT_EN] && !cause[`ST_POR]) |=> s_r.ctrl[`CTRL_WDT_EN])
		else $error("watchdog enable cleared without power-on");
	a_wdt_expiry: assert property (@(posedge i_clock) disable iff (i_rst)
		(s_r.ctrl[`CTRL_WDT_EN] && s_r.wdt_cnt >= s_r.wdt_timeout) |=> ##1 o_device_reset)
		else $error("watchdog expiry gave no reset");
	a_mon_gated: assert property (@(posedge i_clock) disable iff (i_rst)
		(s_r.seq != ST_RUN) |-> !ahv_trip && !alv_trip && !dlv_trip)
		else $error("monitor active before power-on finished");
	a_por_stretch: assert property (@(posedge i_clock) disable iff (i_rst)
		$rose(s_r.seq == ST_RUN) |-> $past(s_r.seq == ST_STRETCH) && !i_por_trip)
		else $error("power-on pulse ended without stretch");
	a_por_holds_reset: assert property (@(posedge i_clock) disable iff (i_rst)
		(s_r.seq != ST_RUN) |=> o_device_reset)
		else $error("device reset released during power-on sequence");
	a_status_record: assert property (@(posedge i_clock) disable iff (i_rst)
		cause[`ST_EXT] |=> s_r.status[`ST_EXT])
		else $error("reset cause not recorded");
	a_irq_wake: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_sleep && o_monitor_irq) |-> $past(!i_sleep))
		else $error("interrupt presented before wake");
endmodule : reset_source_controller

// File: ext_reset_drv.sv
// Purpose: Model of the board driver on the external reset line.
// Assumes: One request pulse starts one low period of i_len cycles.
// Notes: The line idles high, as the on-chip pull-up leaves it.
`timescale 1ns/10ps
`include "rst_ctrl_cfg.svh"

module ext_reset_drv (
	input wire logic i_clock,
	input wire logic i_req,
	input wire logic [7:0] i_len,
	output logic o_ext_reset_n
);
	int hold_r = 0;
	int gap_r = `EXT_GAP_CYCLES;

	// The line rests high until a low period is requested.
	initial o_ext_reset_n = 1'b1;

	// Holds the line low, then refuses a new low period until the gap has run out.
	always @(posedge i_clock) begin
		if (hold_r > 1) begin
			hold_r <= hold_r - 1;
		end else if (hold_r == 1) begin
			hold_r <= 0;
			gap_r <= 0;
			o_ext_reset_n <= 1'b1;
		end else if (i_req && gap_r >= `EXT_GAP_CYCLES) begin
			hold_r <= int'(i_len);
			o_ext_reset_n <= 1'b0;
		end else if (gap_r < `EXT_GAP_CYCLES) begin
			gap_r <= gap_r + 1;
		end
	end
endmodule : ext_reset_drv

// File: reset_source_controller_tb.sv
// Purpose: Self-checking bench for the reset source controller.
// Assumes: 50 MHz clock, synchronous reset held for 12 cycles.
// Notes: Every status read is compared with a fixed expected cause value.
`timescale 1ns/10ps
`include "rst_ctrl_cfg.svh"

module reset_source_controller_tb;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic ext_n, ext_req = 1'b0, prec_trip = 1'b0, high_trip = 1'b0;
	logic i_sleep = 1'b0, boot = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [3:0] alv_sup = 4'hf, i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0000_0000, o_rdata;
	logic o_rst, o_irq, o_wake, o_buzz, o_prec;
	int fails = 0, compares = 0, cyc = 0, st, lv, sup;

	reset_source_controller u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_ext_reset_n(ext_n),
		.i_por_trip(1'b0), .i_prec_dig_trip(prec_trip), .i_prec_ana_trip(1'b0),
		.i_analog_supply_lvl(alv_sup), .i_digital_supply_lvl(4'hf),
		.i_analog_high_trip(high_trip), .i_boot_done(boot), .i_sleep(i_sleep),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_device_reset(o_rst), .o_monitor_irq(o_irq), .o_wake_req(o_wake),
		.o_buzz(o_buzz), .o_prec_enable(o_prec));
	ext_reset_drv u_ext (.i_clock(i_clock), .i_req(ext_req), .i_len(8'h28), .o_ext_reset_n(ext_n));

	// Free-running clock and a hang guard.
	initial begin
		forever #10 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			finish_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input int d);
		i_addr <= a;
		i_wdata <= 32'(d);
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
		@(posedge i_clock);
	endtask : wr
	task automatic rd(input logic [3:0] a, input int e);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		check(o_rdata, 32'(e));
		@(posedge i_clock);
	endtask : rd
	function automatic logic pick(input int s);
		case (s)
			0: return o_rst;
			1: return o_buzz;
			2: return o_irq;
			3: return o_wake;
			default: return o_prec;
		endcase
	endfunction : pick
	// Waits up to n cycles for an output to reach v, then compares it.
	task automatic wait_on(input int s, input logic v, input int n);
		int k;
		k = 0;
		do begin
			@(posedge i_clock);
			#1;
			k++;
		end while (pick(s) !== v && k < n);
		check(32'(pick(s)), 32'(v));
		@(posedge i_clock);
	endtask : wait_on
	task automatic clr();
		wr(`ADDR_STATUS, 255);
		st = 0;
	endtask : clr
	task automatic finish_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test

	// Main sequence: one block per reset source except the digital low-voltage monitor, plus interrupt and sleep blocks.
	initial begin
		st = $urandom(32'h0000_6ee7);
		repeat (10) @(posedge i_clock);
		wait_on(0, 1'b1, 1);
		i_rst <= 1'b0;
		boot <= 1'b1;
		repeat (8) @(posedge i_clock);
		wait_on(0, 1'b1, 1);
		wait_on(0, 1'b0, 20);
		rd(`ADDR_STATUS, 1);
		rd(4'h9, 0);
		wait_on(4, 1'b1, 1);
		$display("test power-on done");
		clr();
		i_sleep <= 1'b1;
		ext_req <= 1'b1;
		@(posedge i_clock);
		ext_req <= 1'b0;
		wait_on(0, 1'b1, 8);
		repeat (20) @(posedge i_clock);
		wait_on(0, 1'b1, 1);
		i_sleep <= 1'b0;
		wait_on(0, 1'b0, 60);
		rd(`ADDR_STATUS, 2);
		$display("test external done");
		clr();
		wr(`ADDR_CTRL, 2);
		wr(`ADDR_CTRL, 3);
		repeat (10) @(posedge i_clock);
		wait_on(0, 1'b0, 1);
		wr(`ADDR_CTRL, 1);
		wait_on(0, 1'b1, 8);
		wait_on(0, 1'b0, 20);
		rd(`ADDR_STATUS, 4);
		$display("test software done");
		clr();
		wr(`ADDR_WDT_TIMEOUT, 30);
		wr(`ADDR_CTRL, 4);
		wr(`ADDR_CTRL, 0);
		wr(`ADDR_WDT_KICK, 0);
		repeat (20) @(posedge i_clock);
		wait_on(0, 1'b0, 1);
		wait_on(0, 1'b1, 40);
		wait_on(0, 1'b0, 20);
		rd(`ADDR_STATUS, 8);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		wait_on(0, 1'b0, 20);
		rd(`ADDR_STATUS, 1);
		wr(`ADDR_WDT_TIMEOUT, 30);
		repeat (60) @(posedge i_clock);
		wait_on(0, 1'b0, 1);
		$display("test watchdog done");
		for (int i = 0; i < 4; i++) begin
			lv = $urandom_range(15, 1);
			sup = $urandom_range(15, 0);
			wr(`ADDR_LVL, lv);
			alv_sup <= 4'(sup);
			wait_on(2, 1'(sup < lv), 6);
			rd(`ADDR_IRQ, int'(sup < lv));
			alv_sup <= 4'hf;
			repeat (3) @(posedge i_clock);
			wr(`ADDR_IRQ, 7);
		end
		clr();
		wr(`ADDR_CTRL, 8);
		wr(`ADDR_LVL, 8);
		alv_sup <= 4'h3;
		wait_on(0, 1'b1, 8);
		alv_sup <= 4'hf;
		wait_on(0, 1'b0, 20);
		rd(`ADDR_STATUS, 32);
		$display("test low supply done");
		clr();
		prec_trip <= 1'b1;
		wait_on(0, 1'b1, 8);
		prec_trip <= 1'b0;
		wait_on(0, 1'b0, 20);
		rd(`ADDR_STATUS, 16);
		$display("test precise done");
		wr(`ADDR_IRQ, 7);
		wr(`ADDR_BUZZ, 16);
		i_sleep <= 1'b1;
		wait_on(1, 1'b1, 40);
		high_trip <= 1'b1;
		wait_on(3, 1'b1, 40);
		wait_on(2, 1'b0, 1);
		i_sleep <= 1'b0;
		wait_on(2, 1'b1, 6);
		rd(`ADDR_IRQ, 4);
		high_trip <= 1'b0;
		$display("test sleep done");
		finish_test();
	end
endmodule : reset_source_controller_tb
